// *** bus_iface_defines.vh ***
// constants for the multiplexed bus interface with write queue
// assumes plain verilog-2005 and inclusion by bare name
`ifndef BUS_IFACE_DEFINES_VH
`define BUS_IFACE_DEFINES_VH

// write queue geometry
`define WQ_DEPTH        4
`define WQ_AW           2
// queue word: addr[31:0], data[63:32], byte enables [67:64]
`define WQ_WIDTH        68
// read queue geometry
`define RQ_DEPTH        4
`define RQ_AW           2

// port width codes held per region
`define PW_8            2'h0
`define PW_16           2'h1
`define PW_32           2'h2
// region select: physical address bits [31:29], eight regions
`define REG_HI          31
`define REG_LO          29
`define PWMAP_W         16
`define PWMAP_RST       16'hAAAA

// bus control fields
`define BC_XHOLD        0
`define BC_TURN         1
`define BC_W            2
`define BC_RST          2'h0

`endif

// *** sync_fifo.v ***
// parameterised synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
module sync_fifo #(
	parameter WIDTH = 68,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             core_clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_r;
	reg [AW-1:0]    rd_ptr_r;
	reg [AW:0]      count_r;
	wire            push;
	wire            pop;

	// handshake terms
	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage write
	always @(posedge core_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// pointers and occupancy
	always @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule

// *** read_queue_mem.v ***
// small four-word read queue memory with registered read data
// assumes the caller never writes and reads the same slot in one cycle
`timescale 1ns/10ps
module read_queue_mem (
	input  wire        core_clk,
	input  wire        wr_en,
	input  wire [1:0]  wr_addr,
	input  wire [31:0] wr_data,
	input  wire [1:0]  rd_addr,
	output reg  [31:0] rd_data
);
	reg [31:0] mem_r [0:3];

	// write port and registered read port
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
		rd_data <= mem_r[rd_addr];
	end
endmodule

// *** muxed_bus_interface.v ***
// Function
// - address then data share one 32-bit pin set each transaction
// - address latch strobe high during address phase; outside uses it
// - reads and writes use request/acknowledge handshake with memory
// - arbiter grants bus to external master, takes it back on release
// - 8, 16 and 32-bit ports handled internally, invisible to software
// - port width chosen per address region from kernel-set map
// - extended hold keeps address an extra clock after strobe falls
// - four-entry store queue holds address and data at core rate
// - queued stores leave in order, paced by memory acknowledge
// - wide stores split into narrower writes for narrow ports
// - every store goes through the queue, write-through
// - bus control setting alters control signal timing
// - single and four-word reads; burst mode when memory keeps pace
// - four-entry read queue, narrow read data packed into words
//
// top of the external bus interface unit; one core clock domain.
// assumes memory acknowledge and the dma request are synchronous.
`timescale 1ns/10ps
`include "bus_iface_defines.vh"
module muxed_bus_interface (
	input  wire        core_clk,
	input  wire        rst,
	input  wire [15:0] port_width_map,
	input  wire [1:0]  bus_ctrl,
	input  wire        st_valid,
	input  wire [31:0] st_addr,
	input  wire [31:0] st_data,
	input  wire [3:0]  st_be,
	output reg         st_ready,
	input  wire        rd_req,
	input  wire [31:0] rd_addr,
	input  wire        rd_quad,
	input  wire        burst_en,
	output reg         rd_word_valid,
	output reg  [31:0] rd_word,
	output reg         rd_done,
	input  wire [31:0] ad_in,
	output reg  [31:0] ad_out,
	output reg         ad_oe,
	output reg         ale,
	output reg         rd_strobe,
	output reg         wr_strobe,
	output reg  [3:0]  byte_en,
	input  wire        ack,
	input  wire        dma_req,
	output reg         dma_grant
);
	// states, one-hot
	localparam S_IDLE  = 7'h01;
	localparam S_ADDR  = 7'h02;
	localparam S_HOLD  = 7'h04;
	localparam S_DATA  = 7'h08;
	localparam S_TURN  = 7'h10;
	localparam S_GRANT = 7'h20;
	localparam S_DRAIN = 7'h40;

	reg  [6:0]  state_r;
	reg         is_rd_r;
	reg  [31:0] cur_addr_r;
	reg  [31:0] cur_data_r;
	reg  [3:0]  cur_be_r;
	reg  [1:0]  pw_r;
	reg  [1:0]  sub_r;
	reg  [1:0]  beat_r;
	reg  [31:0] pack_r;
	reg  [1:0]  wcnt_r;
	reg  [1:0]  rq_wr_r;
	reg  [1:0]  rq_rd_r;
	reg  [2:0]  rq_cnt_r;
	reg         rq_pend_r;
	reg         rd_quad_r;
	reg  [1:0]  nsub;
	reg  [31:0] lane_data;
	reg  [3:0]  lane_be;
	reg  [31:0] pack_nxt;
	wire [`WQ_WIDTH-1:0] wq_out;
	wire        wq_valid;
	reg         wq_pop;
	wire [31:0] rq_data;
	wire [2:0]  region;
	wire [1:0]  pw_sel;
	wire        word_done;
	wire        rq_push;
	reg         rq_push_d_r;
	reg  [2:0]  wq_cnt_r;
	reg  [2:0]  wq_cnt_nxt;
	wire        wq_push;
	wire        rq_take;

	// store queue: every core store enters here
	sync_fifo #(
		.WIDTH (`WQ_WIDTH),
		.DEPTH (`WQ_DEPTH),
		.AW    (`WQ_AW)
	) u_wq (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_data   ({st_be, st_data, st_addr}),
		.in_valid  (st_valid),
		.in_ready  (),
		.out_data  (wq_out),
		.out_valid (wq_valid),
		.out_ready (wq_pop)
	);

	// read queue storage
	read_queue_mem u_rq (
		.core_clk (core_clk),
		.wr_en    (rq_push),
		.wr_addr  (rq_wr_r),
		.wr_data  (pack_nxt),
		.rd_addr  (rq_rd_r),
		.rd_data  (rq_data)
	);

	// region lookup for port width
	// only the store pick uses this; a stale read flag must not steer it
	assign region = wq_out[`REG_HI:`REG_LO];
	assign pw_sel = port_width_map[{region, 1'b0} +: 2];

	// sub-transfers per word minus one, by width
	always @* begin
		case (pw_r)
			`PW_8:   nsub = 2'h3;
			`PW_16:  nsub = 2'h1;
			default: nsub = 2'h0;
		endcase
	end

	// lane steering: move current piece to the low lanes of a narrow port
	always @* begin
		lane_data = cur_data_r;
		lane_be   = cur_be_r;
		if (pw_r == `PW_8) begin
			lane_data = {24'h000000, cur_data_r[{sub_r, 3'h0} +: 8]};
			lane_be   = {3'h0, cur_be_r[sub_r]};
		end else if (pw_r == `PW_16) begin
			lane_data = {16'h0000, cur_data_r[{sub_r[0], 4'h0} +: 16]};
			lane_be   = {2'h0, cur_be_r[{sub_r[0], 1'b0} +: 2]};
		end
	end

	// read packing of narrow port data into a full word
	always @* begin
		pack_nxt = pack_r;
		if (pw_r == `PW_8) begin
			pack_nxt[{sub_r, 3'h0} +: 8] = ad_in[7:0];
		end else if (pw_r == `PW_16) begin
			pack_nxt[{sub_r[0], 4'h0} +: 16] = ad_in[15:0];
		end else begin
			pack_nxt = ad_in;
		end
	end

	assign word_done = (state_r == S_DATA) & ack & (sub_r == nsub);
	assign rq_push   = word_done & is_rd_r;
	// a word written to the read queue is visible at its registered port two cycles on
	assign rq_take   = (rq_cnt_r != 3'h0) & ~rd_word_valid & ~rq_push_d_r &
	                   ((state_r == S_IDLE) | (state_r == S_TURN));

	// store queue occupancy mirror so that st_ready leaves a flip-flop
	assign wq_push = st_valid & st_ready;

	always @* begin
		wq_cnt_nxt = wq_cnt_r;
		if (wq_push & ~wq_pop) begin
			wq_cnt_nxt = wq_cnt_r + 3'h1;
		end else if (wq_pop & ~wq_push) begin
			wq_cnt_nxt = wq_cnt_r - 3'h1;
		end
	end

	// ready drops when four entries are held; only a count of four has bit 2 set
	always @(posedge core_clk) begin
		if (rst) begin
			wq_cnt_r <= 3'h0;
			st_ready <= 1'b1;
		end else begin
			wq_cnt_r <= wq_cnt_nxt;
			st_ready <= ~wq_cnt_nxt[2];
		end
	end

	// main bus sequencer
	always @(posedge core_clk) begin
		if (rst) begin
			state_r    <= S_IDLE;
			is_rd_r    <= 1'b0;
			cur_addr_r <= 32'h00000000;
			cur_data_r <= 32'h00000000;
			cur_be_r   <= 4'h0;
			pw_r       <= `PW_32;
			sub_r      <= 2'h0;
			beat_r     <= 2'h0;
			pack_r     <= 32'h00000000;
			rd_quad_r  <= 1'b0;
			ad_out     <= 32'h00000000;
			ad_oe      <= 1'b0;
			ale        <= 1'b0;
			rd_strobe  <= 1'b0;
			wr_strobe  <= 1'b0;
			byte_en    <= 4'h0;
			dma_grant  <= 1'b0;
			wq_pop     <= 1'b0;
			wcnt_r     <= 2'h0;
			rq_pend_r  <= 1'b0;
		end else begin
			wq_pop <= 1'b0;
			case (state_r)
				S_IDLE: begin
					// external master first, then reads, then stores
					if (dma_req) begin
						dma_grant <= 1'b1;
						ad_oe     <= 1'b0;
						state_r   <= S_GRANT;
					end else if (rd_req & ~rq_pend_r) begin
						is_rd_r    <= 1'b1;
						rd_quad_r  <= rd_quad;
						rq_pend_r  <= 1'b1;
						beat_r     <= 2'h0;
						cur_addr_r <= rd_addr;
						pw_r       <= port_width_map[{rd_addr[`REG_HI:`REG_LO], 1'b0} +: 2];
						sub_r      <= 2'h0;
						state_r    <= S_ADDR;
					end else if (wq_valid & ~wq_pop) begin
						// oldest queued store goes out first
						is_rd_r    <= 1'b0;
						cur_addr_r <= wq_out[31:0];
						cur_data_r <= wq_out[63:32];
						cur_be_r   <= wq_out[67:64];
						pw_r       <= pw_sel;
						sub_r      <= 2'h0;
						state_r    <= S_ADDR;
					end
				end
				S_ADDR: begin
					// address on shared pins with latch strobe
					// byte pieces step by one, halfword pieces by two
					ad_out  <= {cur_addr_r[31:2], 2'h0} +
					           {28'h0000000, beat_r, (pw_r == `PW_16) ? {sub_r[0], 1'b0} : sub_r};
					ad_oe   <= 1'b1;
					ale     <= 1'b1;
					byte_en <= is_rd_r ? 4'hF : lane_be;
					state_r <= bus_ctrl[`BC_XHOLD] ? S_HOLD : S_DATA;
				end
				S_HOLD: begin
					// strobe falls, address held one more slot
					ale     <= 1'b0;
					state_r <= S_DATA;
				end
				S_DATA: begin
					// data phase, ended by memory acknowledge
					ale <= 1'b0;
					if (is_rd_r) begin
						ad_oe     <= 1'b0;
						rd_strobe <= 1'b1;
					end else begin
						ad_out    <= lane_data;
						ad_oe     <= 1'b1;
						wr_strobe <= 1'b1;
					end
					if (ack & (rd_strobe | wr_strobe)) begin
						rd_strobe <= 1'b0;
						wr_strobe <= 1'b0;
						if (is_rd_r) begin
							pack_r <= pack_nxt;
						end
						if (sub_r != nsub) begin
							// next narrow piece
							sub_r   <= sub_r + 2'h1;
							state_r <= S_ADDR;
						end else if (is_rd_r & rd_quad_r & (beat_r != 2'h3)) begin
							// next word of a quad read
							sub_r   <= 2'h0;
							beat_r  <= beat_r + 2'h1;
							state_r <= (burst_en & (nsub == 2'h0)) ? S_DATA : S_ADDR;
						end else begin
							if (~is_rd_r) begin
								wq_pop <= 1'b1;
							end
							ad_oe   <= 1'b0;
							state_r <= (is_rd_r & bus_ctrl[`BC_TURN]) ? S_TURN : S_IDLE;
						end
					end
				end
				S_TURN: begin
					// extra idle slot after reads for bus turnaround
					state_r <= S_IDLE;
				end
				S_GRANT: begin
					// pins released until external master lets go
					if (~dma_req) begin
						dma_grant <= 1'b0;
						state_r   <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
			if (rd_done) begin
				rq_pend_r <= 1'b0;
			end
		end
	end

	// read queue bookkeeping and delivery to the core
	always @(posedge core_clk) begin
		if (rst) begin
			rq_wr_r       <= 2'h0;
			rq_rd_r       <= 2'h0;
			rq_cnt_r      <= 3'h0;
			rd_word_valid <= 1'b0;
			rd_word       <= 32'h00000000;
			rd_done       <= 1'b0;
			rq_push_d_r   <= 1'b0;
		end else begin
			rd_word_valid <= 1'b0;
			rd_done       <= 1'b0;
			rq_push_d_r   <= rq_push;
			if (rq_push) begin
				rq_wr_r <= rq_wr_r + 2'h1;
			end
			// release words once the whole read has arrived
			if (rq_take) begin
				rd_word_valid <= 1'b1;
				rd_word       <= rq_data;
				rq_rd_r       <= rq_rd_r + 2'h1;
				rd_done       <= (rq_cnt_r == 3'h1);
			end
			if (rq_push & ~rq_take) begin
				rq_cnt_r <= rq_cnt_r + 3'h1;
			end else if (rq_take & ~rq_push) begin
				rq_cnt_r <= rq_cnt_r - 3'h1;
			end
		end
	end
endmodule

// *** bus_pins_asserts.sv ***
// checker on the shared pins of the multiplexed bus interface
// assumes binding onto the top module, one clock domain
`timescale 1ns/10ps
module bus_pins_asserts (
	input wire        core_clk,
	input wire        rst,
	input wire [1:0]  bus_ctrl,
	input wire [31:0] ad_out,
	input wire        ad_oe,
	input wire        ale,
	input wire        rd_strobe,
	input wire        wr_strobe,
	input wire [3:0]  byte_en,
	input wire        ack,
	input wire        dma_req,
	input wire        dma_grant
);
	// one clock, reset disables all
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// address phase framing and data turnover
	AST_ALE_PULSE: assert property (ale |=> !ale)
		else $error("ale longer than one cycle");
	AST_ALE_DRIVES: assert property (ale |-> ad_oe && !rd_strobe && !wr_strobe)
		else $error("ale without address on pins");
	AST_DATA_NEXT: assert property (ale && !bus_ctrl[0] |=> rd_strobe || wr_strobe)
		else $error("no data phase after address");
	AST_HOLD: assert property (ale && bus_ctrl[0] |=> !ale && !rd_strobe && !wr_strobe && ad_oe
		&& $stable(ad_out) ##1 (rd_strobe || wr_strobe)) else $error("address hold slot wrong");
	// strobes stand until acknowledge, then end
	AST_STROBE_WAIT: assert property ((rd_strobe || wr_strobe) && !ack |=> rd_strobe || wr_strobe)
		else $error("strobe dropped before ack");
	AST_STROBE_END: assert property ((rd_strobe || wr_strobe) && ack |=> !rd_strobe && !wr_strobe)
		else $error("strobe stays after ack");
	AST_READ_LANES: assert property (rd_strobe |-> byte_en == 4'hF && !ad_oe)
		else $error("read lanes or pin drive wrong");
	AST_WRITE_DRIVE: assert property (wr_strobe |-> ad_oe && byte_en != 4'h0)
		else $error("write data not driven");
	// external master owns the bus quietly and hands it back
	AST_GRANT_QUIET: assert property (dma_grant |-> !ad_oe && !ale && !rd_strobe && !wr_strobe)
		else $error("device active while granted");
	AST_GRANT_BACK: assert property ($fell(dma_req) |-> ##[0:2] !dma_grant)
		else $error("grant not released");
endmodule

// *** ext_memory.sv ***
// model of the memory behind the shared address/data pins
// assumes the device releases the pins while a read is strobed
`timescale 1ns/10ps
module ext_memory (
	input  wire        core_clk,
	input  wire        rst,
	input  wire [31:0] ad_out,
	input  wire        ad_oe,
	input  wire        ale,
	input  wire        rd_strobe,
	input  wire        wr_strobe,
	input  wire [2:0]  delay,
	output reg         ack,
	output wire [31:0] ad_in
);
	reg [31:0] addr_r;
	reg [31:0] last_r;
	reg [2:0]  cnt_r;
	reg [31:0] wa [0:31];
	reg [31:0] wd [0:31];
	integer    n_wr;
	// pin level: device, read data, or a changing pattern when released
	assign ad_in = ad_oe ? ad_out : (rd_strobe ? ~addr_r : ~last_r);
	// latch address, answer after the wait, log writes
	always @(posedge core_clk) begin
		last_r <= ad_in;
		if (ale)
			addr_r <= ad_out;
		else if (rd_strobe && ack)
			addr_r <= addr_r + 32'h4;
		if (rst) begin
			ack <= 1'b0;
			cnt_r <= 3'h0;
			n_wr <= 0;
		end else if ((rd_strobe || wr_strobe) && !ack) begin
			if (cnt_r == delay) begin
				ack <= 1'b1;
				cnt_r <= 3'h0;
				if (wr_strobe) begin
					wa[n_wr] <= addr_r;
					wd[n_wr] <= ad_out;
					n_wr <= n_wr + 1;
				end
			end else
				cnt_r <= cnt_r + 3'h1;
		end else
			ack <= 1'b0;
	end
endmodule

// *** muxed_bus_interface_tb.sv ***
// self-checking bench for the multiplexed bus interface with write queue
// assumes the design files, checker and memory model compile first
`timescale 1ns/10ps
`include "bus_iface_defines.vh"
module muxed_bus_interface_tb;
	reg         core_clk = 1'b0;
	reg         rst = 1'b1;
	reg  [15:0] pw_map = `PWMAP_RST;
	reg  [1:0]  bc = `BC_RST;
	reg         st_valid = 1'b0;
	reg  [31:0] st_addr = 32'h0;
	reg  [31:0] st_data = 32'h0;
	reg         rd_req = 1'b0;
	reg  [31:0] rd_addr = 32'h0;
	reg         rd_quad = 1'b0;
	reg         burst_en = 1'b0;
	reg         dma_req = 1'b0;
	reg  [2:0]  mem_dly = 3'h0;
	wire        st_ready, rd_word_valid, rd_done, ad_oe, ale, rd_strobe, wr_strobe, ack, dma_grant;
	wire [31:0] rd_word;
	wire [31:0] ad_in;
	wire [31:0] ad_out;
	wire [3:0]  byte_en;
	integer     err_total = 0;
	integer     comparisons = 0;
	integer     cyc = 0;
	integer     i, k, acc;
	// clock and hang guard
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	muxed_bus_interface dut (.core_clk(core_clk), .rst(rst), .port_width_map(pw_map), .bus_ctrl(bc),
		.st_valid(st_valid), .st_addr(st_addr), .st_data(st_data), .st_be(4'hF), .st_ready(st_ready),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_quad(rd_quad), .burst_en(burst_en),
		.rd_word_valid(rd_word_valid), .rd_word(rd_word), .rd_done(rd_done), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
		.byte_en(byte_en), .ack(ack), .dma_req(dma_req), .dma_grant(dma_grant));
	ext_memory mem (.core_clk(core_clk), .rst(rst), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale),
		.rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .delay(mem_dly), .ack(ack), .ad_in(ad_in));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// wait for the memory to log n writes
	task wait_wr(input integer n);
		begin
			for (k = 0; mem.n_wr < n && k < 200; k = k + 1)
				@(negedge core_clk);
			chk(mem.n_wr, n);
		end
	endtask
	// one store, held until taken
	task put(input [31:0] a, input [31:0] d);
		begin
			@(negedge core_clk);
			st_valid = 1'b1;
			st_addr = a;
			st_data = d;
			for (k = 0; st_ready !== 1'b1 && k < 100; k = k + 1)
				@(negedge core_clk);
			chk(st_ready, 1);
			@(negedge core_clk);
			st_valid = 1'b0;
		end
	endtask
	task t_fill;
		begin
			mem_dly = 3'h7;
			acc = 0;
			@(negedge core_clk);
			st_valid = 1'b1;
			for (i = 0; i < 7; i = i + 1) begin
				st_data = 32'hD0000000 + acc;
				st_addr = 32'h40000200 + 4 * acc;
				if (st_ready === 1'b1)
					acc = acc + 1;
				@(negedge core_clk);
			end
			chk(acc, 4);
			chk(st_ready, 0);
			st_valid = 1'b0;
			wait_wr(5);
			for (i = 0; i < 4; i = i + 1)
				chk(mem.wd[1 + i], 32'hD0000000 + i);
			mem_dly = 3'h1;
			$display("fill test done");
		end
	endtask
	task t_narrow;
		begin
			pw_map = {12'hAAA, `PW_16, `PW_8};
			put(32'h00000010, 32'h11223344);
			put(32'h20000020, 32'h55667788);
			wait_wr(11);
			for (i = 0; i < 4; i = i + 1) begin
				chk(mem.wa[5 + i], 32'h10 + i);
				chk({24'h0, mem.wd[5 + i][7:0]}, (32'h11223344 >> (8 * i)) & 32'hFF);
			end
			for (i = 0; i < 2; i = i + 1) begin
				chk(mem.wa[9 + i], 32'h20000020 + 2 * i);
				chk({16'h0, mem.wd[9 + i][15:0]}, (32'h55667788 >> (16 * i)) & 32'hFFFF);
			end
			pw_map = `PWMAP_RST;
			$display("narrow port test done");
		end
	endtask
	// x is the first word expected; each later word of a quad is expected four below the one before
	task t_read(input [31:0] a, input q, input b, input [31:0] x);
		begin
			@(negedge core_clk);
			rd_req = 1'b1;
			rd_addr = a;
			rd_quad = q;
			burst_en = b;
			acc = 0;
			for (k = 0; rd_done !== 1'b1 && k < 200; k = k + 1) begin
				@(negedge core_clk);
				if (rd_word_valid === 1'b1) begin
					chk(rd_word, x - 4 * acc);
					acc = acc + 1;
				end
			end
			rd_req = 1'b0;
			chk(acc, q ? 4 : 1);
			$display("read test done");
		end
	endtask
	task t_dma;
		begin
			@(negedge core_clk);
			dma_req = 1'b1;
			for (k = 0; dma_grant !== 1'b1 && k < 20; k = k + 1)
				@(negedge core_clk);
			chk(dma_grant, 1);
			chk(ad_oe, 0);
			dma_req = 1'b0;
			repeat (3) @(negedge core_clk);
			chk(dma_grant, 0);
			$display("dma test done");
		end
	endtask
	task t_single;
		begin
			put(32'h40000100, 32'hCAFEF00D);
			wait_wr(1);
			chk(mem.wa[0], 32'h40000100);
			chk(mem.wd[0], 32'hCAFEF00D);
			$display("single store test done");
		end
	endtask
	task t_hold;
		begin
			bc = 2'h1;
			put(32'h40000300, 32'h0BADCAFE);
			wait_wr(12);
			chk(mem.wa[11], 32'h40000300);
			chk(mem.wd[11], 32'h0BADCAFE);
			$display("address hold test done");
		end
	endtask
	// byte port read: four pieces of the inverted address packed low byte first
	task t_pack;
		begin
			pw_map = {12'hAAA, `PW_16, `PW_8};
			t_read(32'h00000040, 1'b0, 1'b0, 32'hBCBDBEBF);
			pw_map = `PWMAP_RST;
			$display("read packing test done");
		end
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		t_single;
		t_fill;
		t_narrow;
		t_hold;
		bc = 2'h2;
		t_read(32'h40000400, 1'b0, 1'b0, ~32'h40000400);
		t_read(32'h40000500, 1'b1, 1'b1, ~32'h40000500);
		t_read(32'h40000600, 1'b1, 1'b0, ~32'h40000600);
		t_pack;
		t_dma;
		end_sim;
	end
endmodule
bind muxed_bus_interface bus_pins_asserts chk_i (.core_clk(core_clk), .rst(rst), .bus_ctrl(bus_ctrl),
	.ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
	.byte_en(byte_en), .ack(ack), .dma_req(dma_req), .dma_grant(dma_grant));
